// File: common/bsx_map.vh
// Purpose: constants of the branch, skip and shift execution block
// Assumes: APB byte addresses, 32-bit words, registers on word boundaries
// Notes: opcodes are the block's own command encoding
`ifndef BSX_MAP_VH
`define BSX_MAP_VH

// Register byte offsets
`define BSX_OFF_CTRL 8'h00
`define BSX_OFF_OPERAND 8'h04
`define BSX_OFF_IO_ADDR 8'h08
`define BSX_OFF_IO_DATA 8'h0C
`define BSX_OFF_FLAGS 8'h10
`define BSX_OFF_PC 8'h14
`define BSX_OFF_RESULT 8'h18

// Control fields
`define BSX_CTRL_OP_LSB 0
`define BSX_CTRL_OP_MSB 5
`define BSX_CTRL_BIT_LSB 8
`define BSX_CTRL_BIT_MSB 10
`define BSX_CTRL_SEL_LSB 12
`define BSX_CTRL_SEL_MSB 14
`define BSX_CTRL_TWO_WORD 16
`define BSX_CTRL_START 31

// Operand fields
`define BSX_OPD_RD_LSB 0
`define BSX_OPD_RD_MSB 7
`define BSX_OPD_RR_LSB 8
`define BSX_OPD_RR_MSB 15
`define BSX_OPD_K_LSB 16
`define BSX_OPD_K_MSB 22
`define BSX_OPD_P_LSB 24
`define BSX_OPD_P_MSB 28

// Result fields
`define BSX_RES_TAKEN 8
`define BSX_RES_CYC_LSB 9
`define BSX_RES_CYC_MSB 10
`define BSX_RES_BUSY 16
`define BSX_RES_BAD_OP 17

// Status flag positions
`define BSX_FLAG_C 0
`define BSX_FLAG_Z 1
`define BSX_FLAG_N 2
`define BSX_FLAG_V 3
`define BSX_FLAG_S 4
`define BSX_FLAG_H 5
`define BSX_FLAG_T 6
`define BSX_FLAG_I 7

// Reset values
`define BSX_RST_FLAGS 8'h00
`define BSX_RST_PC 16'h0000

// Opcodes
`define BSX_OP_NONE 6'h00
`define BSX_OP_COMPARE_WITH_CARRY 6'h01
`define BSX_OP_COMPARE_IMMEDIATE 6'h02
`define BSX_OP_SKIP_REG_BIT_CLEAR 6'h03
`define BSX_OP_SKIP_REG_BIT_SET 6'h04
`define BSX_OP_SKIP_IO_BIT_CLEAR 6'h05
`define BSX_OP_SKIP_IO_BIT_SET 6'h06
`define BSX_OP_BRANCH_FLAG_SET 6'h07
`define BSX_OP_BRANCH_FLAG_CLEAR 6'h08
`define BSX_OP_BRANCH_EQUAL 6'h09
`define BSX_OP_BRANCH_NOT_EQUAL 6'h0A
`define BSX_OP_BRANCH_CARRY_SET 6'h0B
`define BSX_OP_BRANCH_CARRY_CLEAR 6'h0C
`define BSX_OP_BRANCH_SAME_OR_HIGHER 6'h0D
`define BSX_OP_BRANCH_LOWER 6'h0E
`define BSX_OP_BRANCH_MINUS 6'h0F
`define BSX_OP_BRANCH_PLUS 6'h10
`define BSX_OP_BRANCH_SIGNED_GE 6'h11
`define BSX_OP_BRANCH_SIGNED_LT 6'h12
`define BSX_OP_BRANCH_HALF_CARRY_SET 6'h13
`define BSX_OP_BRANCH_HALF_CARRY_CLEAR 6'h14
`define BSX_OP_BRANCH_TRANSFER_SET 6'h15
`define BSX_OP_BRANCH_TRANSFER_CLEAR 6'h16
`define BSX_OP_BRANCH_OVERFLOW_SET 6'h17
`define BSX_OP_BRANCH_OVERFLOW_CLEAR 6'h18
`define BSX_OP_BRANCH_IRQ_ENABLED 6'h19
`define BSX_OP_BRANCH_IRQ_DISABLED 6'h1A
`define BSX_OP_SET_IO_BIT 6'h1B
`define BSX_OP_CLEAR_IO_BIT 6'h1C
`define BSX_OP_SHIFT_LEFT_LOGICAL 6'h1D
`define BSX_OP_SHIFT_RIGHT_LOGICAL 6'h1E
`define BSX_OP_ROTATE_LEFT_CARRY 6'h1F
`define BSX_OP_ROTATE_RIGHT_CARRY 6'h20

// Instruction cycle counts
`define BSX_CYC_ONE 2'h1
`define BSX_CYC_TWO 2'h2
`define BSX_CYC_THREE 2'h3

`endif

// File: hw/bsx_io_mem.v
// Purpose: small I/O register space with registered read data
// Assumes: one write port, one read port, same clock
// Notes: contents are not reset, only the read register is
`timescale 1ns/100ps
module bsx_io_mem #(
	parameter AW = 5,
	parameter DW = 8
) (
	input wire pclk,
	input wire presetn,
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [DW-1:0] wdata,
	input wire [AW-1:0] raddr,
	output reg [DW-1:0] rdata
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= {DW{1'b0}};
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

// File: hw/bsx_exec.v
// Purpose: executes compare, skip, branch, I/O bit and shift instructions
// Assumes: APB slave, one clock, instruction staged by software
// Notes: every instruction finishes two cycles after start
// Behaviour
// - Compare with carry evaluates Rd-Rr-C and compare immediate Rd-Rr, set Z N V C H, leave Rd, one cycle.
// - Skip on register bit clear or set tests bit b of Rr and skips by 2 or 3, taking 1/2/3 cycles, no flags.
// - Skip on I/O bit clear or set tests bit b of I/O register P and skips, 1/2/3 cycles, no flags.
// - Generic flag branches test status bit s for one or zero and go to PC+k+1, 1 cycle or 2 if taken.
// - Equal, not equal, carry set or lower, carry clear or same-or-higher branch on Z and C.
// - Minus branches on N one and plus on N zero, with no flag change.
// - Signed greater-or-equal branches when N xor V is zero.
// - Half carry branches take H one or H zero, 1 or 2 cycles, flags untouched.
// - Transfer bit branches take T one or T zero to PC+k+1.
// - Overflow-set branch takes V one, 1 cycle or 2 if taken.
// - Interrupt enable branches take I one or I zero, 1 or 2 cycles.
// - Set and clear I/O bit write one or zero to bit b of P, 2 cycles, flags unchanged.
// - Left shift moves bit n to n+1, zero or old carry into bit 0, bit 7 to carry, sets Z C N V.
// - Right shift moves bit n+1 to n, zero or old carry into bit 7, bit 0 to carry, sets Z C N V.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "bsx_map.vh"
module bsx_exec #(
	parameter IO_AW = 5
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr
);
	localparam ST_IDLE = 2'b00;
	localparam ST_FETCH = 2'b01;
	localparam ST_EVAL = 2'b10;

	reg [1:0] state_q;
	reg [5:0] op_q;
	reg [2:0] bit_q;
	reg [2:0] sel_q;
	reg two_word_q;
	reg [7:0] rd_q;
	reg [7:0] rr_q;
	reg [6:0] k_q;
	reg [IO_AW-1:0] p_q;
	reg [IO_AW-1:0] io_addr_q;
	reg [7:0] flags_q;
	reg [15:0] pc_q;
	reg [7:0] res_q;
	reg taken_q;
	reg [1:0] cyc_q;
	reg bad_op_q;
	reg err_q;

	wire [7:0] io_rdata;
	wire busy = (state_q != ST_IDLE);
	wire acc_first = psel & penable & ~pready;
	wire acc_done = psel & penable & pready;
	wire wr_done = acc_done & pwrite & ~err_q;
	wire start = wr_done & (paddr == `BSX_OFF_CTRL) & pwdata[`BSX_CTRL_START];
	wire eval = (state_q == ST_EVAL);

	// APB decode, address and error
	reg mapped;
	reg ro_hit;
	always @* begin
		mapped = 1'b1;
		ro_hit = 1'b0;
		if (paddr == `BSX_OFF_CTRL) begin
			mapped = 1'b1;
		end else if (paddr == `BSX_OFF_OPERAND) begin
			mapped = 1'b1;
		end else if (paddr == `BSX_OFF_IO_ADDR) begin
			mapped = 1'b1;
		end else if (paddr == `BSX_OFF_IO_DATA) begin
			mapped = 1'b1;
		end else if (paddr == `BSX_OFF_FLAGS) begin
			mapped = 1'b1;
		end else if (paddr == `BSX_OFF_PC) begin
			mapped = 1'b1;
		end else if (paddr == `BSX_OFF_RESULT) begin
			ro_hit = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	// Writes during execution would corrupt operands in flight
	wire err_d = ~mapped | (pwrite & (ro_hit | busy));

	reg [31:0] rdata_d;
	always @* begin
		rdata_d = 32'h00000000;
		if (paddr == `BSX_OFF_CTRL) begin
			rdata_d[`BSX_CTRL_OP_MSB:`BSX_CTRL_OP_LSB] = op_q;
			rdata_d[`BSX_CTRL_BIT_MSB:`BSX_CTRL_BIT_LSB] = bit_q;
			rdata_d[`BSX_CTRL_SEL_MSB:`BSX_CTRL_SEL_LSB] = sel_q;
			rdata_d[`BSX_CTRL_TWO_WORD] = two_word_q;
		end else if (paddr == `BSX_OFF_OPERAND) begin
			rdata_d[`BSX_OPD_RD_MSB:`BSX_OPD_RD_LSB] = rd_q;
			rdata_d[`BSX_OPD_RR_MSB:`BSX_OPD_RR_LSB] = rr_q;
			rdata_d[`BSX_OPD_K_MSB:`BSX_OPD_K_LSB] = k_q;
			rdata_d[`BSX_OPD_P_LSB+IO_AW-1:`BSX_OPD_P_LSB] = p_q;
		end else if (paddr == `BSX_OFF_IO_ADDR) begin
			rdata_d[IO_AW-1:0] = io_addr_q;
		end else if (paddr == `BSX_OFF_IO_DATA) begin
			rdata_d[7:0] = io_rdata;
		end else if (paddr == `BSX_OFF_FLAGS) begin
			rdata_d[7:0] = flags_q;
		end else if (paddr == `BSX_OFF_PC) begin
			rdata_d[15:0] = pc_q;
		end else if (paddr == `BSX_OFF_RESULT) begin
			rdata_d[7:0] = res_q;
			rdata_d[`BSX_RES_TAKEN] = taken_q;
			rdata_d[`BSX_RES_CYC_MSB:`BSX_RES_CYC_LSB] = cyc_q;
			rdata_d[`BSX_RES_BUSY] = busy;
			rdata_d[`BSX_RES_BAD_OP] = bad_op_q;
		end
	end

	// One wait state, read data taken while the memory output is settled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			err_q <= 1'b0;
		end else if (acc_first) begin
			pready <= 1'b1;
			pslverr <= err_d;
			err_q <= err_d;
			prdata <= pwrite ? 32'h00000000 : rdata_d;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			err_q <= 1'b0;
		end
	end

	// Instruction evaluation
	wire fl_c = flags_q[`BSX_FLAG_C];
	wire fl_z = flags_q[`BSX_FLAG_Z];
	wire fl_n = flags_q[`BSX_FLAG_N];
	wire fl_v = flags_q[`BSX_FLAG_V];
	wire is_cpc = (op_q == `BSX_OP_COMPARE_WITH_CARRY);
	wire [7:0] cmp_b = rr_q;
	wire cmp_cin = is_cpc & fl_c;
	wire [8:0] cmp_diff = {1'b0, rd_q} - {1'b0, cmp_b} - {8'h00, cmp_cin};
	wire [7:0] cmp_r = cmp_diff[7:0];
	wire cmp_h = (~rd_q[3] & cmp_b[3]) | (cmp_b[3] & cmp_r[3]) | (cmp_r[3] & ~rd_q[3]);
	wire cmp_v = (rd_q[7] & ~cmp_b[7] & ~cmp_r[7]) | (~rd_q[7] & cmp_b[7] & cmp_r[7]);
	// Carry-chained compare keeps Z only if the earlier bytes were equal
	wire cmp_z = (cmp_r == 8'h00) & (~is_cpc | fl_z);
	wire [15:0] br_target = pc_q + {{9{k_q[6]}}, k_q} + 16'h0001;
	wire io_bit = io_rdata[bit_q];
	wire rr_bit = rr_q[bit_q];

	reg [7:0] flags_d;
	reg [15:0] pc_d;
	reg [7:0] res_d;
	reg taken_d;
	reg [1:0] cyc_d;
	reg bad_op_d;
	reg io_we_d;
	reg [7:0] io_wdata_d;
	reg [7:0] sh_r;
	reg sh_c;
	reg cond;
	always @* begin
		flags_d = flags_q;
		pc_d = pc_q + 16'h0001;
		res_d = rd_q;
		taken_d = 1'b0;
		cyc_d = `BSX_CYC_ONE;
		bad_op_d = 1'b0;
		io_we_d = 1'b0;
		io_wdata_d = io_rdata;
		sh_r = rd_q;
		sh_c = fl_c;
		cond = 1'b0;
		case (op_q)
			`BSX_OP_COMPARE_WITH_CARRY, `BSX_OP_COMPARE_IMMEDIATE: begin
				flags_d[`BSX_FLAG_Z] = cmp_z;
				flags_d[`BSX_FLAG_N] = cmp_r[7];
				flags_d[`BSX_FLAG_V] = cmp_v;
				flags_d[`BSX_FLAG_C] = cmp_diff[8];
				flags_d[`BSX_FLAG_H] = cmp_h;
			end
			`BSX_OP_SKIP_REG_BIT_CLEAR, `BSX_OP_SKIP_REG_BIT_SET,
			`BSX_OP_SKIP_IO_BIT_CLEAR, `BSX_OP_SKIP_IO_BIT_SET: begin
				if (op_q == `BSX_OP_SKIP_REG_BIT_CLEAR) begin
					cond = ~rr_bit;
				end else if (op_q == `BSX_OP_SKIP_REG_BIT_SET) begin
					cond = rr_bit;
				end else if (op_q == `BSX_OP_SKIP_IO_BIT_CLEAR) begin
					cond = ~io_bit;
				end else begin
					cond = io_bit;
				end
				taken_d = cond;
				if (cond) begin
					pc_d = pc_q + (two_word_q ? 16'h0003 : 16'h0002);
					cyc_d = two_word_q ? `BSX_CYC_THREE : `BSX_CYC_TWO;
				end
			end
			`BSX_OP_BRANCH_FLAG_SET, `BSX_OP_BRANCH_FLAG_CLEAR,
			`BSX_OP_BRANCH_EQUAL, `BSX_OP_BRANCH_NOT_EQUAL,
			`BSX_OP_BRANCH_CARRY_SET, `BSX_OP_BRANCH_CARRY_CLEAR,
			`BSX_OP_BRANCH_SAME_OR_HIGHER, `BSX_OP_BRANCH_LOWER,
			`BSX_OP_BRANCH_MINUS, `BSX_OP_BRANCH_PLUS,
			`BSX_OP_BRANCH_SIGNED_GE, `BSX_OP_BRANCH_SIGNED_LT,
			`BSX_OP_BRANCH_HALF_CARRY_SET, `BSX_OP_BRANCH_HALF_CARRY_CLEAR,
			`BSX_OP_BRANCH_TRANSFER_SET, `BSX_OP_BRANCH_TRANSFER_CLEAR,
			`BSX_OP_BRANCH_OVERFLOW_SET, `BSX_OP_BRANCH_OVERFLOW_CLEAR,
			`BSX_OP_BRANCH_IRQ_ENABLED, `BSX_OP_BRANCH_IRQ_DISABLED: begin
				if (op_q == `BSX_OP_BRANCH_FLAG_SET) begin
					cond = flags_q[sel_q];
				end else if (op_q == `BSX_OP_BRANCH_FLAG_CLEAR) begin
					cond = ~flags_q[sel_q];
				end else if (op_q == `BSX_OP_BRANCH_EQUAL) begin
					cond = fl_z;
				end else if (op_q == `BSX_OP_BRANCH_NOT_EQUAL) begin
					cond = ~fl_z;
				end else if (op_q == `BSX_OP_BRANCH_CARRY_SET || op_q == `BSX_OP_BRANCH_LOWER) begin
					cond = fl_c;
				end else if (op_q == `BSX_OP_BRANCH_CARRY_CLEAR || op_q == `BSX_OP_BRANCH_SAME_OR_HIGHER) begin
					cond = ~fl_c;
				end else if (op_q == `BSX_OP_BRANCH_MINUS) begin
					cond = fl_n;
				end else if (op_q == `BSX_OP_BRANCH_PLUS) begin
					cond = ~fl_n;
				end else if (op_q == `BSX_OP_BRANCH_SIGNED_GE) begin
					cond = ~(fl_n ^ fl_v);
				end else if (op_q == `BSX_OP_BRANCH_SIGNED_LT) begin
					cond = fl_n ^ fl_v;
				end else if (op_q == `BSX_OP_BRANCH_HALF_CARRY_SET) begin
					cond = flags_q[`BSX_FLAG_H];
				end else if (op_q == `BSX_OP_BRANCH_HALF_CARRY_CLEAR) begin
					cond = ~flags_q[`BSX_FLAG_H];
				end else if (op_q == `BSX_OP_BRANCH_TRANSFER_SET) begin
					cond = flags_q[`BSX_FLAG_T];
				end else if (op_q == `BSX_OP_BRANCH_TRANSFER_CLEAR) begin
					cond = ~flags_q[`BSX_FLAG_T];
				end else if (op_q == `BSX_OP_BRANCH_OVERFLOW_SET) begin
					cond = fl_v;
				end else if (op_q == `BSX_OP_BRANCH_OVERFLOW_CLEAR) begin
					cond = ~fl_v;
				end else if (op_q == `BSX_OP_BRANCH_IRQ_ENABLED) begin
					cond = flags_q[`BSX_FLAG_I];
				end else begin
					cond = ~flags_q[`BSX_FLAG_I];
				end
				taken_d = cond;
				if (cond) begin
					pc_d = br_target;
					cyc_d = `BSX_CYC_TWO;
				end
			end
			`BSX_OP_SET_IO_BIT, `BSX_OP_CLEAR_IO_BIT: begin
				io_we_d = 1'b1;
				io_wdata_d[bit_q] = (op_q == `BSX_OP_SET_IO_BIT);
				cyc_d = `BSX_CYC_TWO;
			end
			`BSX_OP_SHIFT_LEFT_LOGICAL, `BSX_OP_ROTATE_LEFT_CARRY,
			`BSX_OP_SHIFT_RIGHT_LOGICAL, `BSX_OP_ROTATE_RIGHT_CARRY: begin
				if (op_q == `BSX_OP_SHIFT_LEFT_LOGICAL) begin
					sh_r = {rd_q[6:0], 1'b0};
					sh_c = rd_q[7];
				end else if (op_q == `BSX_OP_ROTATE_LEFT_CARRY) begin
					sh_r = {rd_q[6:0], fl_c};
					sh_c = rd_q[7];
				end else if (op_q == `BSX_OP_SHIFT_RIGHT_LOGICAL) begin
					sh_r = {1'b0, rd_q[7:1]};
					sh_c = rd_q[0];
				end else begin
					sh_r = {fl_c, rd_q[7:1]};
					sh_c = rd_q[0];
				end
				res_d = sh_r;
				flags_d[`BSX_FLAG_C] = sh_c;
				flags_d[`BSX_FLAG_Z] = (sh_r == 8'h00);
				flags_d[`BSX_FLAG_N] = sh_r[7];
				flags_d[`BSX_FLAG_V] = sh_r[7] ^ sh_c;
			end
			default: begin
				// Unknown opcode keeps PC and flags and sets the bad opcode result bit
				pc_d = pc_q;
				bad_op_d = 1'b1;
				cyc_d = 2'h0;
			end
		endcase
	end

	// I/O space shared by execution and the software window
	wire apb_io_we = wr_done & (paddr == `BSX_OFF_IO_DATA);
	wire mem_we = (eval & io_we_d) | apb_io_we;
	wire [IO_AW-1:0] mem_waddr = eval ? p_q : io_addr_q;
	wire [IO_AW-1:0] mem_raddr = busy ? p_q : io_addr_q;

	bsx_io_mem #(
		.AW(IO_AW),
		.DW(8)
	) u_io_mem (
		.pclk(pclk),
		.presetn(presetn),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(eval ? io_wdata_d : pwdata[7:0]),
		.raddr(mem_raddr),
		.rdata(io_rdata)
	);

	// Sequencer: fetch presents P to the memory, eval commits
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					state_q <= ST_EVAL;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Software registers and execution results
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q <= `BSX_OP_NONE;
			bit_q <= 3'h0;
			sel_q <= 3'h0;
			two_word_q <= 1'b0;
			rd_q <= 8'h00;
			rr_q <= 8'h00;
			k_q <= 7'h00;
			p_q <= {IO_AW{1'b0}};
			io_addr_q <= {IO_AW{1'b0}};
			flags_q <= `BSX_RST_FLAGS;
			pc_q <= `BSX_RST_PC;
			res_q <= 8'h00;
			taken_q <= 1'b0;
			cyc_q <= 2'h0;
			bad_op_q <= 1'b0;
		end else if (eval) begin
			// Flags that an instruction does not own keep their value
			flags_q <= flags_d;
			pc_q <= pc_d;
			res_q <= res_d;
			taken_q <= taken_d;
			cyc_q <= cyc_d;
			bad_op_q <= bad_op_d;
		end else if (wr_done) begin
			if (paddr == `BSX_OFF_CTRL) begin
				op_q <= pwdata[`BSX_CTRL_OP_MSB:`BSX_CTRL_OP_LSB];
				bit_q <= pwdata[`BSX_CTRL_BIT_MSB:`BSX_CTRL_BIT_LSB];
				sel_q <= pwdata[`BSX_CTRL_SEL_MSB:`BSX_CTRL_SEL_LSB];
				two_word_q <= pwdata[`BSX_CTRL_TWO_WORD];
			end else if (paddr == `BSX_OFF_OPERAND) begin
				rd_q <= pwdata[`BSX_OPD_RD_MSB:`BSX_OPD_RD_LSB];
				rr_q <= pwdata[`BSX_OPD_RR_MSB:`BSX_OPD_RR_LSB];
				k_q <= pwdata[`BSX_OPD_K_MSB:`BSX_OPD_K_LSB];
				p_q <= pwdata[`BSX_OPD_P_LSB+IO_AW-1:`BSX_OPD_P_LSB];
			end else if (paddr == `BSX_OFF_IO_ADDR) begin
				io_addr_q <= pwdata[IO_AW-1:0];
			end else if (paddr == `BSX_OFF_FLAGS) begin
				flags_q <= pwdata[7:0];
			end else if (paddr == `BSX_OFF_PC) begin
				pc_q <= pwdata[15:0];
			end
		end
	end
endmodule

// File: sim/bsx_exec_chk.sv
// Purpose: bus-level checks on the executor's APB slave
// Assumes: sees only the top module's ports
// Notes: instruction results are judged by the bench, not here
`timescale 1ns/100ps
`include "bsx_map.vh"
module bsx_exec_chk (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr
);
	wire mapped;
	assign mapped = (paddr == `BSX_OFF_CTRL) || (paddr == `BSX_OFF_OPERAND) || (paddr == `BSX_OFF_IO_ADDR) ||
		(paddr == `BSX_OFF_IO_DATA) || (paddr == `BSX_OFF_FLAGS) || (paddr == `BSX_OFF_PC) ||
		(paddr == `BSX_OFF_RESULT);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		s_setup ##1 (psel && penable);
	endsequence
	a_one_wait: assert property (s_access |=> pready) else $error("ready late after access start");
	a_first_access: assert property (psel && penable && !$past(penable) |-> !pready)
		else $error("ready without wait state");
	a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access phase");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
	a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0) else $error("read data on write");
	a_unmapped_err: assert property (pready && !mapped |-> pslverr) else $error("unmapped access accepted");
	a_result_ro: assert property (pready && pwrite && paddr == `BSX_OFF_RESULT |-> pslverr)
		else $error("result write accepted");
	a_read_ok: assert property (pready && !pwrite && mapped |-> !pslverr) else $error("mapped read refused");
	a_flags_width: assert property (pready && !pwrite && paddr == `BSX_OFF_FLAGS |-> prdata[31:8] == 24'h0)
		else $error("flags upper bits set");
endmodule

// File: sim/test_branch_skip_shift_exec.sv
// Purpose: self-checking bench for the branch, skip and shift executor
// Assumes: APB master on rising edges, slave answers when it likes
// Notes: expectations are worked out here, never read back from the design
`timescale 1ns/100ps
`include "bsx_map.vh"
module test_branch_skip_shift_exec;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, rres, rfl, rpc;
	int n_errors = 0;
	int checks_done = 0;

	bsx_exec u_bsx_exec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task give_verdict;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 8);
		if (pready !== 1'b1) begin
			n_errors++;
			give_verdict;
		end
		r = prdata;
		chk({31'h0, pslverr}, {31'h0, e});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Start only once the operands are staged; writes while busy would be refused
	task run(input logic [31:0] ctrl, input logic [31:0] opd, input logic [7:0] fl, input logic [15:0] pc);
		int n;
		xfer(1'b1, `BSX_OFF_OPERAND, opd, 1'b0);
		xfer(1'b1, `BSX_OFF_FLAGS, {24'h0, fl}, 1'b0);
		xfer(1'b1, `BSX_OFF_PC, {16'h0, pc}, 1'b0);
		xfer(1'b1, `BSX_OFF_CTRL, ctrl | 32'h8000_0000, 1'b0);
		n = 0;
		do begin
			xfer(1'b0, `BSX_OFF_RESULT, 32'h0, 1'b0);
			n++;
		end while (r[16] !== 1'b0 && n < 4);
		if (r[16] !== 1'b0) begin
			n_errors++;
			give_verdict;
		end
		rres = r;
		xfer(1'b0, `BSX_OFF_FLAGS, 32'h0, 1'b0);
		rfl = r;
		xfer(1'b0, `BSX_OFF_PC, 32'h0, 1'b0);
		rpc = r;
	endtask

	task judge(input logic [1:0] cyc, input logic tk, input logic [7:0] fl, input logic [15:0] pc,
		input logic [7:0] res);
		chk({13'h0, rres[10:8], rfl[7:0], rres[7:0]}, {13'h0, cyc, tk, fl, res});
		chk(rpc, {16'h0, pc});
	endtask

	function automatic logic bt(input logic [5:0] op, input logic [7:0] f, input logic [2:0] s);
		logic b;
		case (op)
			6'h07, 6'h08: b = f[s];
			6'h09, 6'h0A: b = f[1];
			6'h0B, 6'h0C: b = f[0];
			6'h0D, 6'h0E: b = !f[0];
			6'h0F, 6'h10: b = f[2];
			6'h11, 6'h12: b = !(f[2] ^ f[3]);
			6'h13, 6'h14: b = f[5];
			6'h15, 6'h16: b = f[6];
			6'h17, 6'h18: b = f[3];
			default: b = f[7];
		endcase
		bt = op[0] ? b : !b;
	endfunction

	task t_reset;
		xfer(1'b0, `BSX_OFF_FLAGS, 32'h0, 1'b0);
		chk(r, 32'h0);
		xfer(1'b0, `BSX_OFF_PC, 32'h0, 1'b0);
		chk(r, 32'h0);
	endtask

	task t_compare;
		run({26'h0, `BSX_OP_COMPARE_IMMEDIATE}, 32'h0000_2010, 8'h00, 16'h0010);
		judge(2'h1, 1'b0, 8'h05, 16'h0011, 8'h10);
		run({26'h0, `BSX_OP_COMPARE_WITH_CARRY}, 32'h0000_7F80, 8'h03, 16'h0010);
		judge(2'h1, 1'b0, 8'h2A, 16'h0011, 8'h80);
	endtask

	task t_skip;
		run(32'h0001_0300 | `BSX_OP_SKIP_REG_BIT_SET, 32'h0000_0800, 8'hA5, 16'h0100);
		judge(2'h3, 1'b1, 8'hA5, 16'h0103, 8'h00);
		run(32'h0001_0300 | `BSX_OP_SKIP_REG_BIT_CLEAR, 32'h0000_0800, 8'hA5, 16'h0100);
		judge(2'h1, 1'b0, 8'hA5, 16'h0101, 8'h00);
		xfer(1'b1, `BSX_OFF_IO_ADDR, 32'h3, 1'b0);
		xfer(1'b1, `BSX_OFF_IO_DATA, 32'h04, 1'b0);
		run(32'h0000_0200 | `BSX_OP_SKIP_IO_BIT_CLEAR, 32'h0300_0000, 8'hA5, 16'h0100);
		judge(2'h1, 1'b0, 8'hA5, 16'h0101, 8'h00);
		run(32'h0000_0200 | `BSX_OP_SKIP_IO_BIT_SET, 32'h0300_0000, 8'hA5, 16'h0100);
		judge(2'h2, 1'b1, 8'hA5, 16'h0102, 8'h00);
		run(32'h0001_0700 | `BSX_OP_SKIP_IO_BIT_CLEAR, 32'h0300_0000, 8'hA5, 16'h0100);
		judge(2'h3, 1'b1, 8'hA5, 16'h0103, 8'h00);
	endtask

	// Offset -3 from 1 wraps the counter, catching a missing sign extension
	task t_branch;
		logic [7:0] pat [3];
		logic [5:0] op;
		logic tk;
		logic [15:0] tgt;
		pat = '{8'h00, 8'h55, 8'hAA};
		for (int p = 0; p < 3; p++) begin
			for (op = 6'h07; op <= 6'h1A; op++) begin
				tk = bt(op, pat[p], op[2:0]);
				tgt = tk ? 16'hFFFF : 16'h0002;
				run({17'h0, op[2:0], 6'h0, op}, 32'h007D_0000, pat[p], 16'h0001);
				judge(tk ? 2'h2 : 2'h1, tk, pat[p], tgt, 8'h00);
			end
		end
	endtask

	task t_io_bit;
		xfer(1'b1, `BSX_OFF_IO_ADDR, 32'h5, 1'b0);
		xfer(1'b1, `BSX_OFF_IO_DATA, 32'hF0, 1'b0);
		run(32'h0000_0100 | `BSX_OP_SET_IO_BIT, 32'h0500_0000, 8'h3C, 16'h0020);
		judge(2'h2, 1'b0, 8'h3C, 16'h0021, 8'h00);
		xfer(1'b0, `BSX_OFF_IO_DATA, 32'h0, 1'b0);
		chk(r, 32'h0000_00F2);
		run(32'h0000_0700 | `BSX_OP_CLEAR_IO_BIT, 32'h0500_0000, 8'h3C, 16'h0020);
		judge(2'h2, 1'b0, 8'h3C, 16'h0021, 8'h00);
		xfer(1'b0, `BSX_OFF_IO_DATA, 32'h0, 1'b0);
		chk(r, 32'h0000_0072);
	endtask

	task t_shift;
		logic [5:0] ops [5];
		logic [7:0] rd [5], fi [5], res [5], fo [5];
		ops = '{`BSX_OP_SHIFT_LEFT_LOGICAL, `BSX_OP_ROTATE_LEFT_CARRY, `BSX_OP_SHIFT_RIGHT_LOGICAL,
			`BSX_OP_ROTATE_RIGHT_CARRY, `BSX_OP_SHIFT_RIGHT_LOGICAL};
		rd = '{8'h81, 8'h81, 8'h81, 8'h81, 8'h01};
		fi = '{8'h11, 8'h11, 8'h11, 8'h11, 8'h10};
		res = '{8'h02, 8'h03, 8'h40, 8'hC0, 8'h00};
		fo = '{8'h19, 8'h19, 8'h19, 8'h15, 8'h1B};
		for (int i = 0; i < 5; i++) begin
			run({26'h0, ops[i]}, {24'h0, rd[i]}, fi[i], 16'h0040);
			judge(2'h1, 1'b0, fo[i], 16'h0041, res[i]);
		end
	endtask

	task t_refuse;
		xfer(1'b0, 8'h1C, 32'h0, 1'b1);
		xfer(1'b1, 8'h20, 32'h0, 1'b1);
		xfer(1'b1, `BSX_OFF_RESULT, 32'h1, 1'b1);
		run(32'h0000_003F, 32'h0, 8'h81, 16'h0200);
		judge(2'h0, 1'b0, 8'h81, 16'h0200, 8'h00);
		chk({31'h0, rres[17]}, 32'h1);
	endtask

	// Back-to-back write lands in the evaluation cycle, so it must be refused
	task t_busy;
		int n;
		xfer(1'b1, `BSX_OFF_FLAGS, 32'h0, 1'b0);
		xfer(1'b1, `BSX_OFF_PC, 32'h0000_0030, 1'b0);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= 1'b1;
		paddr <= `BSX_OFF_CTRL;
		pwdata <= 32'h8000_0000 | `BSX_OP_BRANCH_EQUAL;
		for (int t = 0; t < 2; t++) begin
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (pready !== 1'b1 && n < 8);
			if (pready !== 1'b1) begin
				n_errors++;
				give_verdict;
			end
			chk({31'h0, pslverr}, {31'h0, t[0]});
			penable <= 1'b0;
			paddr <= `BSX_OFF_FLAGS;
			pwdata <= 32'h0000_00FF;
		end
		psel <= 1'b0;
		xfer(1'b0, `BSX_OFF_FLAGS, 32'h0, 1'b0);
		chk(r, 32'h0);
		xfer(1'b0, `BSX_OFF_PC, 32'h0, 1'b0);
		chk(r, 32'h0000_0031);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_compare;
		t_skip;
		t_branch;
		t_io_bit;
		t_shift;
		t_refuse;
		t_busy;
		give_verdict;
	end
endmodule

bind bsx_exec bsx_exec_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
